/* core/lp_cycle_pkg.sv */
// constants, field layouts and carriers of the light and proximity cycle control block
// assumes a byte-wide register port driven by a serial front end outside this block
`default_nettype none
package lp_cycle_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [4:0] ADDR_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_LIGHT_TIME = 5'h01;
	localparam logic [4:0] ADDR_PROX_TIME = 5'h02;
	localparam logic [4:0] ADDR_WAIT = 5'h03;
	localparam logic [4:0] ADDR_LIGHT_LOW_LSB = 5'h04;
	localparam logic [4:0] ADDR_LIGHT_LOW_MSB = 5'h05;
	localparam logic [4:0] ADDR_LIGHT_HIGH_LSB = 5'h06;
	localparam logic [4:0] ADDR_LIGHT_HIGH_MSB = 5'h07;
	localparam logic [4:0] ADDR_PROX_LOW_LSB = 5'h08;
	localparam logic [4:0] ADDR_PROX_LOW_MSB = 5'h09;
	localparam logic [4:0] ADDR_PROX_HIGH_LSB = 5'h0A;
	localparam logic [4:0] ADDR_PROX_HIGH_MSB = 5'h0B;
	localparam logic [4:0] ADDR_CONFIG = 5'h0D;
	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int BIT_RESERVED = 7;
	localparam int BIT_SLEEP_AFTER_IRQ = 6;
	localparam int BIT_PROX_IRQ_MASK = 5;
	localparam int BIT_LIGHT_IRQ_MASK = 4;
	localparam int BIT_WAIT_ENABLE = 3;
	localparam int BIT_PROX_FUNCTION_ON = 2;
	localparam int BIT_LIGHT_FUNCTION_ON = 1;
	localparam int BIT_OSCILLATOR_POWER = 0;
	localparam int BIT_LONG_WAIT_SELECT = 1;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_TIME = 8'hFF;
	localparam logic [7:0] RST_LIMIT = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] CONFIG_WRITE_MASK = 8'h07;
	// ****************************************
	// special-function commands
	// ****************************************
	localparam logic [4:0] CMD_CLEAR_PROX = 5'h05;
	localparam logic [4:0] CMD_CLEAR_LIGHT = 5'h06;
	localparam logic [4:0] CMD_CLEAR_BOTH = 5'h07;
	// ****************************************
	// timing
	// ****************************************
	localparam real STEP_TIME_NS = 2730000.0;
	localparam real CLOCK_PERIOD_NS = 25.0;
	localparam int STEP_CYCLES = int'(STEP_TIME_NS / CLOCK_PERIOD_NS);
	localparam int LONG_WAIT_FACTOR = 12;
	localparam logic [16:0] LIGHT_COUNT_PER_STEP = 17'h00400;
	localparam logic [16:0] LIGHT_COUNT_MAX = 17'h0FFFF;
	localparam logic [15:0] PROX_COUNT_MAX = 16'h03FF;

	typedef enum logic [2:0] {ST_SLEEP, ST_PROX, ST_WAIT, ST_LIGHT, ST_END} cycle_state_t;

	typedef struct packed {
		logic write;
		logic read;
		logic command;
		logic [4:0] addr;
		logic [7:0] data;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] channel_zero_result;
		logic [15:0] prox_result;
	} sense_result_t;
endpackage
`default_nettype wire

/* core/lp_step_timer.sv */
// counts whole timer steps while the oscillator runs
// assumes a single clock; the caller holds i_run low outside timed phases, which clears the timer
`timescale 1ns/1ps
`default_nettype none
module lp_step_timer
	import lp_cycle_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic i_long,
	output logic o_step
);
	typedef struct packed {
		logic [17:0] tick;
		logic [3:0] rep;
		logic step;
	} timer_state_t;
	timer_state_t s_q, s_d;
	localparam logic [17:0] TICK_LAST = 18'(STEP_CYCLES - 1);
	localparam logic [3:0] REP_LAST = 4'(LONG_WAIT_FACTOR - 1);

	always_comb begin
		s_d = s_q;
		s_d.step = 1'b0;
		if (!i_run) begin
			s_d.tick = '0;
			s_d.rep = '0;
		end else if (s_q.tick == TICK_LAST) begin
			s_d.tick = '0;
			// long steps are twelve base steps back to back
			if (!i_long || s_q.rep == REP_LAST) begin
				s_d.rep = '0;
				s_d.step = 1'b1;
			end else begin
				s_d.rep = s_q.rep + 4'h1;
			end
		end else begin
			s_d.tick = s_q.tick + 18'h00001;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_step = s_q.step;
endmodule // lp_step_timer
`default_nettype wire

/* core/lp_cycle_control.sv */
// register file, measurement cycle sequencer and threshold interrupts
// assumes the serial front end hands over decoded byte accesses, one per cycle
// and that results arrive from the converters at the end of each phase
`timescale 1ns/1ps
`default_nettype none
module lp_cycle_control
	import lp_cycle_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire reg_req_t i_req,
	input wire sense_result_t i_result,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_oscillator_on,
	output logic o_prox_active,
	output logic o_light_active,
	output logic o_wait_active,
	output logic [16:0] o_light_max_count
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] light_time;
		logic [7:0] prox_time;
		logic [7:0] wait_time;
		logic [7:0] config_reg;
		logic [15:0] light_low;
		logic [15:0] light_high;
		logic [15:0] prox_low;
		logic [15:0] prox_high;
		cycle_state_t phase;
		logic [8:0] steps;
		logic prox_irq;
		logic light_irq;
		logic irq_in_cycle;
		logic [7:0] rdata;
		logic irq;
		logic [16:0] light_max;
		logic [2:0] active;
	} ctrl_state_t;
	ctrl_state_t s_q, s_d;
	logic step;
	logic timer_run;

	// number of steps held in a time register: 256 minus the value
	function automatic logic [8:0] steps_of(input logic [7:0] v);
		steps_of = 9'h100 - {1'b0, v};
	endfunction

	function automatic logic [15:0] pair_set(input logic [15:0] old, input logic upper, input logic [7:0] b);
		pair_set = upper ? {b, old[7:0]} : {old[15:8], b};
	endfunction

	function automatic logic outside(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		outside = (v < lo) || (v > hi);
	endfunction

	// next phase after the one ending; skipped functions are passed over
	function automatic cycle_state_t next_after(input cycle_state_t p, input logic [7:0] c);
		next_after = ST_END;
		case (p)
			ST_SLEEP: begin
				if (c[BIT_PROX_FUNCTION_ON]) begin
					next_after = ST_PROX;
				end else if (c[BIT_WAIT_ENABLE]) begin
					next_after = ST_WAIT;
				end else if (c[BIT_LIGHT_FUNCTION_ON]) begin
					next_after = ST_LIGHT;
				end
			end
			ST_PROX: begin
				if (c[BIT_WAIT_ENABLE]) begin
					next_after = ST_WAIT;
				end else if (c[BIT_LIGHT_FUNCTION_ON]) begin
					next_after = ST_LIGHT;
				end
			end
			ST_WAIT: begin
				if (c[BIT_LIGHT_FUNCTION_ON]) begin
					next_after = ST_LIGHT;
				end
			end
			default: next_after = ST_END;
		endcase
	endfunction

	function automatic logic [8:0] phase_len(input cycle_state_t p, input ctrl_state_t s);
		case (p)
			ST_PROX: phase_len = steps_of(s.prox_time);
			ST_WAIT: phase_len = steps_of(s.wait_time);
			ST_LIGHT: phase_len = steps_of(s.light_time);
			default: phase_len = 9'h001;
		endcase
	endfunction

	// ****************************************
	// step timer
	// ****************************************
	// runs from the edge that enters a timed phase, so a phase is whole steps with no extra cycle
	assign timer_run = s_d.control[BIT_OSCILLATOR_POWER] && (s_d.phase == ST_PROX || s_d.phase == ST_WAIT ||
		s_d.phase == ST_LIGHT);

	lp_step_timer u_timer (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_run(timer_run),
		.i_long(s_q.phase == ST_WAIT && s_q.config_reg[BIT_LONG_WAIT_SELECT]),
		.o_step(step)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [18:0] lmax;
		logic set_prox;
		logic set_light;
		logic clr_prox;
		logic clr_light;
		cycle_state_t nxt;
		lmax = '0;
		set_prox = 1'b0;
		set_light = 1'b0;
		clr_prox = 1'b0;
		clr_light = 1'b0;
		nxt = ST_END;
		s_d = s_q;

		// register writes and reads
		if (i_req.write && i_req.command) begin
			clr_prox = (i_req.addr == CMD_CLEAR_PROX) || (i_req.addr == CMD_CLEAR_BOTH);
			clr_light = (i_req.addr == CMD_CLEAR_LIGHT) || (i_req.addr == CMD_CLEAR_BOTH);
		end else if (i_req.write) begin
			if (i_req.addr == ADDR_CONTROL) begin
				s_d.control = {1'b0, i_req.data[6:0]};
			end else if (i_req.addr == ADDR_LIGHT_TIME) begin
				s_d.light_time = i_req.data;
			end else if (i_req.addr == ADDR_PROX_TIME) begin
				s_d.prox_time = i_req.data;
			end else if (i_req.addr == ADDR_WAIT) begin
				s_d.wait_time = i_req.data;
			end else if (i_req.addr == ADDR_CONFIG) begin
				s_d.config_reg = i_req.data & CONFIG_WRITE_MASK;
			end else if (i_req.addr == ADDR_LIGHT_LOW_LSB || i_req.addr == ADDR_LIGHT_LOW_MSB) begin
				s_d.light_low = pair_set(s_q.light_low, i_req.addr[0], i_req.data);
			end else if (i_req.addr == ADDR_LIGHT_HIGH_LSB || i_req.addr == ADDR_LIGHT_HIGH_MSB) begin
				s_d.light_high = pair_set(s_q.light_high, i_req.addr[0], i_req.data);
			end else if (i_req.addr == ADDR_PROX_LOW_LSB || i_req.addr == ADDR_PROX_LOW_MSB) begin
				s_d.prox_low = pair_set(s_q.prox_low, i_req.addr[0], i_req.data);
			end else if (i_req.addr == ADDR_PROX_HIGH_LSB || i_req.addr == ADDR_PROX_HIGH_MSB) begin
				s_d.prox_high = pair_set(s_q.prox_high, i_req.addr[0], i_req.data);
			end
		end

		if (i_req.read) begin
			if (i_req.addr == ADDR_CONTROL) begin
				s_d.rdata = s_q.control;
			end else if (i_req.addr == ADDR_LIGHT_TIME) begin
				s_d.rdata = s_q.light_time;
			end else if (i_req.addr == ADDR_PROX_TIME) begin
				s_d.rdata = s_q.prox_time;
			end else if (i_req.addr == ADDR_WAIT) begin
				s_d.rdata = s_q.wait_time;
			end else if (i_req.addr == ADDR_CONFIG) begin
				s_d.rdata = s_q.config_reg;
			end else if (i_req.addr == ADDR_LIGHT_LOW_LSB) begin
				s_d.rdata = s_q.light_low[7:0];
			end else if (i_req.addr == ADDR_LIGHT_LOW_MSB) begin
				s_d.rdata = s_q.light_low[15:8];
			end else if (i_req.addr == ADDR_LIGHT_HIGH_LSB) begin
				s_d.rdata = s_q.light_high[7:0];
			end else if (i_req.addr == ADDR_LIGHT_HIGH_MSB) begin
				s_d.rdata = s_q.light_high[15:8];
			end else if (i_req.addr == ADDR_PROX_LOW_LSB) begin
				s_d.rdata = s_q.prox_low[7:0];
			end else if (i_req.addr == ADDR_PROX_LOW_MSB) begin
				s_d.rdata = s_q.prox_low[15:8];
			end else if (i_req.addr == ADDR_PROX_HIGH_LSB) begin
				s_d.rdata = s_q.prox_high[7:0];
			end else if (i_req.addr == ADDR_PROX_HIGH_MSB) begin
				s_d.rdata = s_q.prox_high[15:8];
			end else begin
				s_d.rdata = 8'h00;
			end
		end

		// measurement cycle sequencer
		case (s_q.phase)
			ST_SLEEP: begin
				if (s_q.control[BIT_OSCILLATOR_POWER]) begin
					nxt = next_after(ST_SLEEP, s_q.control);
					if (nxt != ST_END) begin
						s_d.phase = nxt;
						s_d.steps = phase_len(nxt, s_q);
						s_d.irq_in_cycle = 1'b0;
					end
				end
			end
			ST_PROX, ST_WAIT, ST_LIGHT: begin
				if (!s_q.control[BIT_OSCILLATOR_POWER]) begin
					s_d.phase = ST_SLEEP;
				end else if (step && s_q.steps == 9'h001) begin
					if (s_q.phase == ST_PROX) begin
						set_prox = outside(i_result.prox_result, s_q.prox_low, s_q.prox_high);
					end
					if (s_q.phase == ST_LIGHT) begin
						set_light = outside(i_result.channel_zero_result, s_q.light_low, s_q.light_high);
						// steps times counts per step, worked out wide so 256 steps cannot wrap, then saturated
						lmax = 19'(steps_of(s_q.light_time)) * 19'(LIGHT_COUNT_PER_STEP);
						s_d.light_max = (lmax > 19'(LIGHT_COUNT_MAX)) ? LIGHT_COUNT_MAX : 17'(lmax);
					end
					nxt = next_after(s_q.phase, s_q.control);
					s_d.phase = nxt;
					s_d.steps = phase_len(nxt, s_q);
				end else if (step) begin
					s_d.steps = s_q.steps - 9'h001;
				end
			end
			default: begin
				// end of a full cycle: with sleep after interrupt set, drop power if an interrupt was raised in it
				if (s_q.control[BIT_SLEEP_AFTER_IRQ] && s_q.irq_in_cycle) begin
					s_d.control[BIT_OSCILLATOR_POWER] = 1'b0;
				end
				s_d.phase = ST_SLEEP;
			end
		endcase

		// masks gate the setting of each flag; sets win over a clear in the same cycle
		set_prox = set_prox && s_q.control[BIT_PROX_IRQ_MASK];
		set_light = set_light && s_q.control[BIT_LIGHT_IRQ_MASK];
		s_d.prox_irq = set_prox || (s_q.prox_irq && !clr_prox);
		s_d.light_irq = set_light || (s_q.light_irq && !clr_light);
		if (set_prox || set_light) begin
			s_d.irq_in_cycle = 1'b1;
		end
		s_d.irq = s_d.prox_irq || s_d.light_irq;
		s_d.active = {s_d.phase == ST_WAIT, s_d.phase == ST_LIGHT, s_d.phase == ST_PROX};
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
			s_q.control <= RST_CONTROL;
			s_q.light_time <= RST_TIME;
			s_q.prox_time <= RST_TIME;
			s_q.wait_time <= RST_TIME;
			s_q.config_reg <= RST_CONFIG;
			s_q.light_low <= {RST_LIMIT, RST_LIMIT};
			s_q.light_high <= {RST_LIMIT, RST_LIMIT};
			s_q.prox_low <= {RST_LIMIT, RST_LIMIT};
			s_q.prox_high <= {RST_LIMIT, RST_LIMIT};
			s_q.phase <= ST_SLEEP;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_irq = s_q.irq;
	assign o_oscillator_on = s_q.control[BIT_OSCILLATOR_POWER];
	assign o_prox_active = s_q.active[0];
	assign o_light_active = s_q.active[1];
	assign o_wait_active = s_q.active[2];
	assign o_light_max_count = s_q.light_max;

	// ****************************************
	// checks
	// ****************************************
	sequence s_clear_prox;
		i_req.write && i_req.command && i_req.addr == CMD_CLEAR_PROX;
	endsequence

	property p_prox_mask;
		@(posedge i_core_clk) disable iff (i_rst)
		!s_q.control[BIT_PROX_IRQ_MASK] && !s_q.prox_irq |=> !s_q.prox_irq;
	endproperty
	a_prox_mask: assert property (p_prox_mask) else $error("prox flag set while masked");

	property p_light_mask;
		@(posedge i_core_clk) disable iff (i_rst)
		!s_q.control[BIT_LIGHT_IRQ_MASK] && !s_q.light_irq |=> !s_q.light_irq;
	endproperty
	a_light_mask: assert property (p_light_mask) else $error("light flag set while masked");

	property p_sticky;
		@(posedge i_core_clk) disable iff (i_rst)
		s_q.prox_irq && !(i_req.write && i_req.command) |=> s_q.prox_irq;
	endproperty
	a_sticky: assert property (p_sticky) else $error("prox flag dropped without clear");

	property p_clear;
		@(posedge i_core_clk) disable iff (i_rst)
		s_clear_prox and !(s_q.phase == ST_PROX && step) |=> !s_q.prox_irq;
	endproperty
	a_clear: assert property (p_clear) else $error("prox clear ignored");

	property p_no_power;
		@(posedge i_core_clk) disable iff (i_rst)
		!s_q.control[BIT_OSCILLATOR_POWER] |=> ##1 s_q.phase == ST_SLEEP || s_q.control[BIT_OSCILLATOR_POWER];
	endproperty
	a_no_power: assert property (p_no_power) else $error("phase runs without power");

	property p_no_wait;
		@(posedge i_core_clk) disable iff (i_rst)
		!s_q.control[BIT_WAIT_ENABLE] && s_q.phase != ST_WAIT && !i_req.write |=> s_q.phase != ST_WAIT;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("wait phase entered while disabled");

	property p_no_prox;
		@(posedge i_core_clk) disable iff (i_rst)
		!s_q.control[BIT_PROX_FUNCTION_ON] && s_q.phase != ST_PROX && !i_req.write |=> s_q.phase != ST_PROX;
	endproperty
	a_no_prox: assert property (p_no_prox) else $error("prox phase entered while disabled");

	property p_no_light;
		@(posedge i_core_clk) disable iff (i_rst)
		!s_q.control[BIT_LIGHT_FUNCTION_ON] && s_q.phase != ST_LIGHT && !i_req.write |=> s_q.phase != ST_LIGHT;
	endproperty
	a_no_light: assert property (p_no_light) else $error("light phase entered while disabled");

	property p_sleep_after;
		@(posedge i_core_clk) disable iff (i_rst)
		s_q.phase == ST_END && s_q.control[BIT_SLEEP_AFTER_IRQ] && s_q.irq_in_cycle && !i_req.write
		|=> !s_q.control[BIT_OSCILLATOR_POWER];
	endproperty
	a_sleep_after: assert property (p_sleep_after) else $error("no power down after interrupt");

	property p_irq_out;
		@(posedge i_core_clk) disable iff (i_rst)
		s_q.phase == ST_PROX && step && s_q.steps == 9'h001 && s_q.control[BIT_OSCILLATOR_POWER] &&
		s_q.control[BIT_PROX_IRQ_MASK] && outside(i_result.prox_result, s_q.prox_low, s_q.prox_high) |=> o_irq;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("irq output missing after proximity out of range");
endmodule // lp_cycle_control
`default_nettype wire

/* sim/lp_host_model.sv */
// host side model: issues byte register accesses and special commands
// assumes the bench calls its tasks; requests change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module lp_host_model
	import lp_cycle_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	output var reg_req_t o_req
);
	// ****************************************
	// request tasks
	// ****************************************
	initial o_req = '0;

	// one request every two cycles, held one cycle and released at the next falling edge after it was taken
	task automatic put(input reg_req_t req);
		@(negedge i_core_clk);
		o_req = req;
		@(negedge i_core_clk);
		o_req = '0;
	endtask

	task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
		logic [7:0] d;
		d = (addr == ADDR_CONTROL) ? (data & 8'h7F) : data;
		put('{write: 1'b1, read: 1'b0, command: 1'b0, addr: addr, data: d});
	endtask

	task automatic read_reg(input logic [4:0] addr, output logic [7:0] data);
		put('{write: 1'b0, read: 1'b1, command: 1'b0, addr: addr, data: 8'h00});
		data = i_rdata;
	endtask

	task automatic command(input logic [4:0] code);
		put('{write: 1'b1, read: 1'b0, command: 1'b1, addr: code, data: 8'h00});
	endtask
endmodule // lp_host_model
`default_nettype wire

/* sim/tb.sv */
// self-checking bench of the light and proximity cycle control block
// assumes the host model drives the register port; step length is fixed,
// so only one proximity cycle (about 109k clocks) fits in the run
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lp_cycle_pkg::*;
	logic i_core_clk;
	logic i_rst;
	reg_req_t req;
	sense_result_t result;
	logic [7:0] rdata;
	logic irq, osc_on, prox_act, light_act, wait_act;
	int num_errors = 0;
	int checked = 0;

	lp_cycle_control i_lp_cycle_control(.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(req), .i_result(result),
		.o_rdata(rdata), .o_irq(irq), .o_oscillator_on(osc_on), .o_prox_active(prox_act),
		.o_light_active(light_act), .o_wait_active(wait_act), .o_light_max_count());
	lp_host_model i_lp_host_model(.i_core_clk(i_core_clk), .i_rdata(rdata), .o_req(req));

	// ****************************************
	// clock, watchdog, verdict
	// ****************************************
	initial i_core_clk = 1'b0;
	always #12.5 i_core_clk = ~i_core_clk;

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one step plus a margin for the register traffic
	initial begin
		#((STEP_CYCLES + 2000) * CLOCK_PERIOD_NS);
		num_errors++;
		complete_run();
	end

	// ****************************************
	// scenarios
	// ****************************************
	task automatic reset_values();
		logic [7:0] d;
		for (int a = 0; a < 12; a++) begin
			i_lp_host_model.read_reg(a[4:0], d);
			check($sformatf("reset reg %0d", a), (a >= 1 && a <= 3) ? RST_TIME : RST_LIMIT, d);
		end
		i_lp_host_model.read_reg(ADDR_CONFIG, d);
		check("reset config", RST_CONFIG, d);
		i_lp_host_model.read_reg(5'h1F, d);
		check("unmapped read", 8'h00, d);
	endtask

	// distinct byte everywhere so a swapped or shared byte shows up
	task automatic readback();
		logic [7:0] d;
		i_lp_host_model.write_reg(ADDR_CONTROL, 8'h7E);
		i_lp_host_model.write_reg(ADDR_CONFIG, 8'h06);
		for (int a = 1; a < 12; a++) begin
			i_lp_host_model.write_reg(a[4:0], {a[3:0], ~a[3:0]});
		end
		for (int a = 1; a < 12; a++) begin
			i_lp_host_model.read_reg(a[4:0], d);
			check($sformatf("readback reg %0d", a), {a[3:0], ~a[3:0]}, d);
		end
		i_lp_host_model.read_reg(ADDR_CONTROL, d);
		check("readback control", 8'h7E, d);
		i_lp_host_model.read_reg(ADDR_CONFIG, d);
		check("readback config", 8'h06, d);
		i_lp_host_model.write_reg(ADDR_CONTROL, 8'h00);
		i_lp_host_model.write_reg(ADDR_CONFIG, 8'h00);
	endtask

	task automatic prox_cycle();
		logic [7:0] d;
		logic other;
		int n;
		other = 1'b0;
		i_lp_host_model.write_reg(ADDR_PROX_TIME, 8'hFF);
		i_lp_host_model.write_reg(ADDR_WAIT, 8'hFF);
		i_lp_host_model.write_reg(ADDR_PROX_LOW_LSB, 8'h00);
		i_lp_host_model.write_reg(ADDR_PROX_LOW_MSB, 8'h01);
		i_lp_host_model.write_reg(ADDR_PROX_HIGH_LSB, 8'h00);
		i_lp_host_model.write_reg(ADDR_PROX_HIGH_MSB, 8'h02);
		result.prox_result = 16'h0300;
		i_lp_host_model.write_reg(ADDR_CONTROL, 8'h65);
		n = 0;
		while (prox_act !== 1'b1 && n < 5) begin
			@(negedge i_core_clk);
			n++;
		end
		check("oscillator on", 1'b1, osc_on);
		check("prox phase", 1'b1, prox_act);
		n = 0;
		while (prox_act === 1'b1 && n < STEP_CYCLES + 10) begin
			other = other | (wait_act === 1'b1) | (light_act === 1'b1);
			@(negedge i_core_clk);
			n++;
		end
		check("prox phase length", STEP_CYCLES, n);
		n = 0;
		while (irq !== 1'b1 && n < 4) begin
			@(negedge i_core_clk);
			n++;
		end
		check("prox irq", 1'b1, irq);
		n = 0;
		while (osc_on !== 1'b0 && n < 8) begin
			other = other | (wait_act === 1'b1) | (light_act === 1'b1);
			@(negedge i_core_clk);
			n++;
		end
		check("sleep after irq", 1'b0, osc_on);
		check("no wait or light phase", 1'b0, other);
		repeat (20) @(negedge i_core_clk);
		check("irq held", 1'b1, irq);
		i_lp_host_model.read_reg(ADDR_CONTROL, d);
		check("power bit dropped", 8'h64, d);
		i_lp_host_model.command(CMD_CLEAR_LIGHT);
		repeat (2) @(negedge i_core_clk);
		check("irq after light clear", 1'b1, irq);
		i_lp_host_model.command(CMD_CLEAR_PROX);
		repeat (2) @(negedge i_core_clk);
		check("irq after prox clear", 1'b0, irq);
		i_lp_host_model.command(CMD_CLEAR_BOTH);
		repeat (2) @(negedge i_core_clk);
		check("irq after both clear", 1'b0, irq);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		i_rst = 1'b1;
		result = '0;
		repeat (5) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_rst = 1'b0;
		reset_values();
		readback();
		prox_cycle();
		complete_run();
	end
endmodule // tb
`default_nettype wire
